// *** design/rwu_pkg.sv ***
package rwu_pkg;
    localparam int unsigned CLK_MHZ = 100;
    // register indices on the plain port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_FUSE = 4'h2;
    localparam int unsigned CTRL_WDE_BIT = 0;
    localparam int unsigned CTRL_WDP_LSB = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int unsigned ST_PB_BIT = 0;
    localparam int unsigned ST_BO_BIT = 1;
    localparam int unsigned ST_WD_BIT = 2;
    localparam int unsigned ST_RUN_BIT = 3;
    localparam int unsigned FUSE_BOE_BIT = 0;
    localparam int unsigned FUSE_BOL_BIT = 1;
    localparam int unsigned FUSE_SUT_LSB = 2;
    localparam int unsigned FUSE_OSC_LSB = 4;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // brown-out levels in millivolts
    localparam logic [12:0] BO_LOW_MV = 13'h0A8C;
    localparam logic [12:0] BO_HIGH_MV = 13'h0FA0;
    localparam logic [12:0] BO_HYST_MV = 13'h0064;
    // watchdog
    localparam int unsigned WD_CNT_W = 22;
    localparam logic [21:0] WD_BASE_TICKS = 22'h004000;
    // start-up delays in microseconds, selected by fuse
    localparam int unsigned SU_CNT_W = 16;
    localparam int unsigned SU_US_0 = 1;
    localparam int unsigned SU_US_1 = 4;
    localparam int unsigned SU_US_2 = 16;
    localparam int unsigned SU_US_3 = 64;
    localparam int unsigned SU_CYC_0 = SU_US_0 * CLK_MHZ;
    localparam int unsigned SU_CYC_1 = SU_US_1 * CLK_MHZ;
    localparam int unsigned SU_CYC_2 = SU_US_2 * CLK_MHZ;
    localparam int unsigned SU_CYC_3 = SU_US_3 * CLK_MHZ;
    localparam logic [13:0] RESET_VECTOR = 14'h0000;
    typedef enum logic [1:0] {
        RWU_HOLD,
        RWU_LAUNCH,
        RWU_RUN
    } rwu_state_t;
endpackage

// *** design/rwu_wd_counter.sv ***
`timescale 1ns/1ps
module rwu_wd_counter (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic tick,
    input wire logic [rwu_pkg::WD_CNT_W-1:0] limit,
    output logic timeout,
    output logic [rwu_pkg::WD_CNT_W-1:0] count
);
    logic [rwu_pkg::WD_CNT_W-1:0] next_count;
    logic next_timeout;

    always_comb begin
        next_count = count;
        next_timeout = 1'b0;
        if (clear) begin
            next_count = '0;
        end else if (tick) begin
            if (count == limit - 1'b1) begin
                next_count = '0;
                next_timeout = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            timeout <= 1'b0;
        end else begin
            count <= next_count;
            timeout <= next_timeout;
        end
    end

    a_clear_zeroes: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clear |=> count == '0 && !timeout) else $error("watchdog count not zero after clear");
    a_timeout_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
        timeout |-> $past(tick) && $past(count) == $past(limit) - 1'b1) else $error("timeout without limit");
endmodule

// *** design/rwu_startup_delay.sv ***
`timescale 1ns/1ps
module rwu_startup_delay (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hold,
    input wire logic [rwu_pkg::SU_CNT_W-1:0] delay_cycles,
    output logic busy
);
    logic [rwu_pkg::SU_CNT_W-1:0] cnt;
    logic [rwu_pkg::SU_CNT_W-1:0] next_cnt;
    logic armed;
    logic next_armed;
    logic next_busy;

    // armed forces a full delay after power-up even without any source
    always_comb begin
        next_cnt = cnt;
        next_armed = 1'b0;
        if (hold || armed) begin
            next_cnt = delay_cycles;
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
        next_busy = hold || armed || next_cnt != '0;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= '0;
            armed <= 1'b1;
            busy <= 1'b1;
        end else begin
            cnt <= next_cnt;
            armed <= next_armed;
            busy <= next_busy;
        end
    end

    a_hold_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
        hold |=> busy) else $error("not busy while held");
endmodule

// *** design/rwu_top.sv ***
`timescale 1ns/1ps
// Contract
// - enabled watchdog reaching its time-out forces a full chip reset.
// - watchdog clear instruction returns the counter to zero.
// - time-out is 16384 watchdog oscillator cycles shifted left by prescale code.
// - pushbutton reset restarts execution at the reset vector.
// - reset returns every I/O register to its initial value; a chip reset leaves the status cause flags set, only reset_n clears them.
// - after reset input release, internal reset holds for a start-up delay.
// - brown-out holds reset while supply is low, only if fuse enabled.
// - level fuse picks the 2.7 V or 4.0 V brown-out threshold.
// - after supply recovers past hysteresis, a time-out precedes release.
// - fuses select oscillator option and start-up delay length; the delay after a reset_n release always has the SU_CYC3 length.
module rwu_top #(
    parameter logic [21:0] WD_BASE = rwu_pkg::WD_BASE_TICKS,
    parameter int unsigned SU_CYC3 = rwu_pkg::SU_CYC_3
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic pushbutton_n,
    input wire logic [12:0] supply_mv,
    input wire logic brownout_enable_fuse,
    input wire logic brownout_level_fuse,
    input wire logic [1:0] startup_sel_fuse,
    input wire logic [3:0] osc_sel_fuse,
    input wire logic wd_osc_tick,
    input wire logic watchdog_clear_instr,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    output logic chip_reset_n,
    output logic vector_load,
    output logic [13:0] vector_addr,
    output logic cpu_run,
    output logic [3:0] osc_select
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic sel(input logic [3:0] a, input logic [3:0] idx);
        sel = a == idx;
    endfunction

    function automatic logic [rwu_pkg::SU_CNT_W-1:0] su_cycles(input logic [1:0] code);
        case (code)
            2'h0: su_cycles = rwu_pkg::SU_CNT_W'(rwu_pkg::SU_CYC_0);
            2'h1: su_cycles = rwu_pkg::SU_CNT_W'(rwu_pkg::SU_CYC_1);
            2'h2: su_cycles = rwu_pkg::SU_CNT_W'(rwu_pkg::SU_CYC_2);
            default: su_cycles = rwu_pkg::SU_CNT_W'(SU_CYC3);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic bo_low;
    logic next_bo_low;
    logic [12:0] bo_thresh;
    logic wd_timeout;
    logic [rwu_pkg::WD_CNT_W-1:0] wd_count;
    logic [rwu_pkg::WD_CNT_W-1:0] wd_limit;
    logic wd_clear;
    logic src_any;
    logic busy;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [2:0] cause;
    logic [2:0] next_cause;
    logic [7:0] next_rd_data;
    logic [1:0] sut_latched;
    logic [1:0] next_sut_latched;
    logic [3:0] next_osc_select;
    rwu_pkg::rwu_state_t state;
    rwu_pkg::rwu_state_t next_state;
    logic next_chip_reset_n;
    logic next_vector_load;
    logic next_cpu_run;
    logic wd_en;
    logic [2:0] wd_prescale;

    assign wd_en = ctrl[rwu_pkg::CTRL_WDE_BIT];
    assign wd_prescale = ctrl[rwu_pkg::CTRL_WDP_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // brown-out comparator with hysteresis
    always_comb begin
        bo_thresh = brownout_level_fuse ? rwu_pkg::BO_HIGH_MV : rwu_pkg::BO_LOW_MV;
        next_bo_low = 1'b0;
        if (brownout_enable_fuse) begin
            if (bo_low) begin
                next_bo_low = supply_mv < bo_thresh + rwu_pkg::BO_HYST_MV;
            end else begin
                next_bo_low = supply_mv < bo_thresh;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bo_low <= 1'b0;
        end else begin
            bo_low <= next_bo_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    assign wd_limit = WD_BASE << wd_prescale;
    // disabled watchdog is held at zero so enabling starts a full interval
    assign wd_clear = watchdog_clear_instr || !chip_reset_n || !wd_en;

    rwu_wd_counter u_wd (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clear(wd_clear),
        .tick(wd_osc_tick),
        .limit(wd_limit),
        .timeout(wd_timeout),
        .count(wd_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset combining and start-up delay
    assign src_any = !pushbutton_n || bo_low || wd_timeout;

    rwu_startup_delay u_su (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .hold(src_any),
        .delay_cycles(su_cycles(sut_latched)),
        .busy(busy)
    );

    // fuses are sampled while in reset so a change takes effect on the next release
    always_comb begin
        next_sut_latched = sut_latched;
        next_osc_select = osc_select;
        if (busy) begin
            next_sut_latched = startup_sel_fuse;
            next_osc_select = osc_sel_fuse;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sut_latched <= 2'h3;
            osc_select <= 4'h0;
        end else begin
            sut_latched <= next_sut_latched;
            osc_select <= next_osc_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // launch sequence
    always_comb begin
        next_state = state;
        next_vector_load = 1'b0;
        next_cpu_run = 1'b0;
        next_chip_reset_n = !busy;
        case (state)
            rwu_pkg::RWU_HOLD: begin
                if (!busy) begin
                    next_state = rwu_pkg::RWU_LAUNCH;
                    next_vector_load = 1'b1;
                end
            end
            rwu_pkg::RWU_LAUNCH: begin
                next_state = busy ? rwu_pkg::RWU_HOLD : rwu_pkg::RWU_RUN;
                next_cpu_run = !busy;
            end
            rwu_pkg::RWU_RUN: begin
                if (busy) begin
                    next_state = rwu_pkg::RWU_HOLD;
                end else begin
                    next_cpu_run = 1'b1;
                end
            end
            default: begin
                next_state = rwu_pkg::RWU_HOLD;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= rwu_pkg::RWU_HOLD;
            chip_reset_n <= 1'b0;
            vector_load <= 1'b0;
            cpu_run <= 1'b0;
            vector_addr <= rwu_pkg::RESET_VECTOR;
        end else begin
            state <= next_state;
            chip_reset_n <= next_chip_reset_n;
            vector_load <= next_vector_load;
            cpu_run <= next_cpu_run;
            vector_addr <= rwu_pkg::RESET_VECTOR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_comb begin
        next_ctrl = ctrl;
        next_cause = cause;
        if (!chip_reset_n) begin
            next_ctrl = rwu_pkg::CTRL_RESET;
        end else if (wr_stb && sel(addr, rwu_pkg::ADDR_CTRL)) begin
            next_ctrl = {4'h0, wr_data[3:0]};
        end
        // write one clears; a new event in the same cycle wins
        if (wr_stb && sel(addr, rwu_pkg::ADDR_STATUS)) begin
            next_cause = cause & ~wr_data[2:0];
        end
        if (!pushbutton_n) begin
            next_cause[rwu_pkg::ST_PB_BIT] = 1'b1;
        end
        if (bo_low) begin
            next_cause[rwu_pkg::ST_BO_BIT] = 1'b1;
        end
        if (wd_timeout) begin
            next_cause[rwu_pkg::ST_WD_BIT] = 1'b1;
        end
        next_rd_data = rwu_pkg::READ_ZERO;
        if (rd_stb) begin
            if (sel(addr, rwu_pkg::ADDR_CTRL)) begin
                next_rd_data = ctrl;
            end else if (sel(addr, rwu_pkg::ADDR_STATUS)) begin
                next_rd_data = {4'h0, cpu_run, cause};
            end else if (sel(addr, rwu_pkg::ADDR_FUSE)) begin
                next_rd_data = {osc_select, sut_latched, brownout_level_fuse, brownout_enable_fuse};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= rwu_pkg::CTRL_RESET;
            cause <= 3'h0;
            rd_data <= rwu_pkg::READ_ZERO;
        end else begin
            ctrl <= next_ctrl;
            cause <= next_cause;
            rd_data <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a source reaches chip_reset_n two edges later: busy first, then the output flop
    a_wd_forces_reset: assert property (wd_timeout |=> ##1 !chip_reset_n)
        else $error("watchdog time-out did not reset chip");
    a_wd_limit_value: assert property (wd_limit == 22'(WD_BASE * (22'h000001 << wd_prescale)))
        else $error("watchdog limit wrong");
    a_bo_src_reset: assert property (bo_low |=> ##1 !chip_reset_n)
        else $error("brown-out did not reset chip");
    a_wd_idle_zero: assert property (!wd_en |=> wd_count == '0)
        else $error("disabled watchdog counted");
    a_wd_idle_quiet: assert property (!wd_en |=> !wd_timeout)
        else $error("disabled watchdog timed out");
    // cause flags: a new event must win over a write-one-clear
    a_cause_wd: assert property (wd_timeout |=> cause[rwu_pkg::ST_WD_BIT])
        else $error("watchdog cause not recorded");
    a_cause_pb: assert property (!pushbutton_n |=> cause[rwu_pkg::ST_PB_BIT])
        else $error("pushbutton cause not recorded");
    a_cause_bo: assert property (bo_low |=> cause[rwu_pkg::ST_BO_BIT])
        else $error("brown-out cause not recorded");

    // launch sequence, control register, watchdog, start-up and brown-out checks
    a_vector_pulse: assert property (vector_load |=> !vector_load)
        else $error("vector load longer than one cycle");
    a_run_after_vector: assert property (vector_load |=> cpu_run || !chip_reset_n)
        else $error("no run after vector load");
    a_cpu_run_out: assert property (cpu_run |-> chip_reset_n)
        else $error("running while chip in reset");
    a_ctrl_write: assert property (chip_reset_n && wr_stb && addr == rwu_pkg::ADDR_CTRL |=> ctrl == ($past(wr_data) & 8'h0F))
        else $error("control write not taken");
    a_wd_cleared_reset: assert property (!chip_reset_n |=> wd_count == '0)
        else $error("watchdog not cleared during chip reset");
    a_pb_holds_reset: assert property (!pushbutton_n |=> ##1 !chip_reset_n)
        else $error("pushbutton did not reset chip");
    a_vector_on_release: assert property ($rose(chip_reset_n) |-> vector_load && vector_addr == rwu_pkg::RESET_VECTOR)
        else $error("no vector load at release");
    a_ctrl_init: assert property (!chip_reset_n |=> ctrl == rwu_pkg::CTRL_RESET)
        else $error("control register not reinitialised");
    a_startup_delay: assert property ($fell(src_any) && sut_latched == 2'h0 |=> !chip_reset_n [*8])
        else $error("start-up delay too short");
    a_bo_gate: assert property (!brownout_enable_fuse |=> !bo_low)
        else $error("brown-out active while disabled");
    a_bo_level: assert property (brownout_enable_fuse && !bo_low && supply_mv < bo_thresh |=> bo_low)
        else $error("brown-out threshold missed");
    a_bo_hyst: assert property (bo_low && brownout_enable_fuse && supply_mv < bo_thresh + rwu_pkg::BO_HYST_MV |=> bo_low)
        else $error("brown-out released inside hysteresis");
    a_bo_release: assert property (bo_low && supply_mv >= bo_thresh + rwu_pkg::BO_HYST_MV |=> !bo_low)
        else $error("brown-out held above hysteresis");
    // reset_n in the antecedent: the edge that releases reset still sees reset values
    a_osc_latch: assert property (reset_n && busy |=> osc_select == $past(osc_sel_fuse))
        else $error("oscillator option not taken in reset");
    a_sut_latch: assert property (reset_n && busy |=> sut_latched == $past(startup_sel_fuse))
        else $error("start-up code not taken in reset");
    a_rd_one_cycle: assert property (!rd_stb |=> rd_data == rwu_pkg::READ_ZERO)
        else $error("read data outside read cycle");
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    localparam int SU3 = 20;
    localparam int WDB = 16;
    logic ref_clk, reset_n, pushbutton_n, brownout_enable_fuse, brownout_level_fuse;
    logic [12:0] supply_mv;
    logic [1:0] startup_sel_fuse;
    logic [3:0] osc_sel_fuse, addr, osc_select;
    logic wd_osc_tick, watchdog_clear_instr, wr_stb, rd_stb, chip_reset_n, vector_load, cpu_run, rd_seen;
    logic [7:0] wr_data, rd_data;
    logic [13:0] vector_addr;
    logic [7:0] exp_q[$];
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    int n_low = 0;

    rwu_top #(.WD_BASE(22'h000010), .SU_CYC3(SU3)) rwu_top_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .pushbutton_n(pushbutton_n), .supply_mv(supply_mv),
        .brownout_enable_fuse(brownout_enable_fuse), .brownout_level_fuse(brownout_level_fuse),
        .startup_sel_fuse(startup_sel_fuse), .osc_sel_fuse(osc_sel_fuse), .wd_osc_tick(wd_osc_tick),
        .watchdog_clear_instr(watchdog_clear_instr), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .chip_reset_n(chip_reset_n), .vector_load(vector_load),
        .vector_addr(vector_addr), .cpu_run(cpu_run), .osc_select(osc_select)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    function automatic int su_cyc(input int c);
        case (c)
            0: return rwu_pkg::SU_CYC_0;
            1: return rwu_pkg::SU_CYC_1;
            2: return rwu_pkg::SU_CYC_2;
            default: return SU3;
        endcase
    endfunction

    // hang guard: whole run is well under this
    always @(posedge ref_clk) begin
        cyc++;
        if (chip_reset_n !== 1'b1) n_low++;
        if (cyc == 30000) begin
            err_total++;
            conclude();
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk) rd_seen <= rd_stb;
    always @(negedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) check("rd_queue", 1, 0);
            else check("rd_data", exp_q.pop_front(), rd_data);
        end
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
    endtask

    task automatic wait_rst(input logic v, input int lim, output int k);
        k = 0;
        while (chip_reset_n !== v && k < lim) begin
            @(negedge ref_clk);
            k++;
        end
    endtask

    // release timing, vector fetch, then run
    task automatic released(input int d, input int k);
        check("release_window", 1, (k >= d && k <= d + 4));
        check("vector_load", 1, vector_load);
        check("vector_addr", 0, vector_addr);
        @(negedge ref_clk);
        check("cpu_run", 1, cpu_run);
        check("vector_load_end", 0, vector_load);
    endtask

    function automatic logic [7:0] fuse_rb();
        return {osc_sel_fuse, startup_sel_fuse, brownout_level_fuse, brownout_enable_fuse};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h6A2178FF));
        reset_n = 1'b0;
        pushbutton_n = 1'b1;
        supply_mv = 13'h1388;
        brownout_enable_fuse = 1'b0;
        brownout_level_fuse = 1'b0;
        startup_sel_fuse = 2'h3;
        osc_sel_fuse = 4'h5;
        wd_osc_tick = 1'b0;
        watchdog_clear_instr = 1'b0;
        addr = 4'h0;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (12) @(posedge ref_clk);
        check("chip_reset_in_reset", 0, chip_reset_n);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        wait_rst(1'b1, SU3 + 10, n);
        released(SU3, n);
        rd(rwu_pkg::ADDR_CTRL, rwu_pkg::CTRL_RESET);
        rd(4'hF, rwu_pkg::READ_ZERO);
        rd(rwu_pkg::ADDR_FUSE, fuse_rb());
        rd(rwu_pkg::ADDR_STATUS, 8'h08);
        // pushbutton over every start-up code; ctrl must come back cleared
        for (int c = 0; c < 4; c++) begin
            wr(rwu_pkg::ADDR_CTRL, 8'h0B);
            @(posedge ref_clk);
            startup_sel_fuse <= 2'(c);
            osc_sel_fuse <= 4'($urandom);
            pushbutton_n <= 1'b0;
            @(negedge ref_clk);
            wait_rst(1'b0, 4, n);
            check("pb_assert", 1, n <= 3);
            repeat (5) @(posedge ref_clk);
            pushbutton_n <= 1'b1;
            @(negedge ref_clk);
            wait_rst(1'b1, su_cyc(c) + 10, n);
            released(su_cyc(c), n);
            check("osc_select", osc_sel_fuse, osc_select);
            rd(rwu_pkg::ADDR_CTRL, rwu_pkg::CTRL_RESET);
            rd(rwu_pkg::ADDR_FUSE, fuse_rb());
            rd(rwu_pkg::ADDR_STATUS, 8'h09);
            wr(rwu_pkg::ADDR_STATUS, 8'h07);
            rd(rwu_pkg::ADDR_STATUS, 8'h08);
        end
        startup_sel_fuse <= 2'h3;
        // watchdog time-out for every prescale code
        for (int p = 0; p < 8; p++) begin
            wr(rwu_pkg::ADDR_CTRL, {4'h0, 3'(p), 1'b1});
            @(posedge ref_clk);
            wd_osc_tick <= 1'b1;
            @(negedge ref_clk);
            wait_rst(1'b0, (WDB << p) + 8, n);
            check("wd_timeout", 1, (n >= (WDB << p) && n <= (WDB << p) + 4));
            @(posedge ref_clk);
            wd_osc_tick <= 1'b0;
            @(negedge ref_clk);
            wait_rst(1'b1, SU3 + 10, n);
            check("wd_release", 1, chip_reset_n);
            @(negedge ref_clk);
            rd(rwu_pkg::ADDR_CTRL, rwu_pkg::CTRL_RESET);
            rd(rwu_pkg::ADDR_STATUS, 8'h0C);
            wr(rwu_pkg::ADDR_STATUS, 8'h07);
        end
        // clears keep it alive; disabled it never fires
        wr(rwu_pkg::ADDR_CTRL, 8'h01);
        n_low = 0;
        @(posedge ref_clk);
        wd_osc_tick <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            repeat (12) @(posedge ref_clk);
            watchdog_clear_instr <= 1'b1;
            @(posedge ref_clk);
            watchdog_clear_instr <= 1'b0;
        end
        repeat (12) @(posedge ref_clk);
        // any reset cycle inside the window means a clear or the disable failed
        check("wd_cleared", 0, n_low);
        wr(rwu_pkg::ADDR_CTRL, 8'h00);
        n_low = 0;
        repeat (40) @(posedge ref_clk);
        check("wd_disabled", 0, n_low);
        wd_osc_tick <= 1'b0;
        // brown-out: fuse gate, threshold, hysteresis, release delay
        @(posedge ref_clk);
        supply_mv <= 13'(2000 + $urandom % 600);
        repeat (10) @(posedge ref_clk);
        check("bo_fuse_off", 1, chip_reset_n);
        brownout_enable_fuse <= 1'b1;
        @(negedge ref_clk);
        wait_rst(1'b0, 4, n);
        check("bo_low", 0, chip_reset_n);
        @(posedge ref_clk);
        supply_mv <= 13'(2700 + $urandom % 100);
        repeat (30) @(posedge ref_clk);
        check("bo_hyst", 0, chip_reset_n);
        supply_mv <= 13'(2800 + $urandom % 1000);
        @(negedge ref_clk);
        wait_rst(1'b1, SU3 + 10, n);
        released(SU3, n);
        rd(rwu_pkg::ADDR_STATUS, 8'h0A);
        @(posedge ref_clk);
        brownout_level_fuse <= 1'b1;
        supply_mv <= 13'(3000 + $urandom % 1000);
        @(negedge ref_clk);
        wait_rst(1'b0, 4, n);
        check("bo_high_level", 0, chip_reset_n);
        @(posedge ref_clk);
        supply_mv <= 13'(4100 + $urandom % 2000);
        @(negedge ref_clk);
        wait_rst(1'b1, SU3 + 10, n);
        released(SU3, n);
        rd(rwu_pkg::ADDR_STATUS, 8'h0A);
        // mid-run reset: only this clears the cause flags
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        wait_rst(1'b1, SU3 + 10, n);
        released(SU3, n);
        rd(rwu_pkg::ADDR_STATUS, 8'h08);
        rd(rwu_pkg::ADDR_CTRL, rwu_pkg::CTRL_RESET);
        repeat (4) @(posedge ref_clk);
        conclude();
    end
endmodule
